/* File: spd_pkg.sv */
// Purpose: Shared constants and types for the speed pulse divider
// Assumes: 200 MHz system clock
// Notes: Register map is APB, one aligned 32-bit word per register
package spd_pkg;
   localparam int unsigned SPD_CLK_HZ = 200000000;
   localparam int unsigned SPD_MIN_FREQ_HZ = 1;
   // Standstill window: one period of the minimum frequency
   localparam int unsigned SPD_STILL_CYC = SPD_CLK_HZ / SPD_MIN_FREQ_HZ;
   localparam int unsigned SPD_STILL_W = 28;
   localparam int unsigned SPD_DIV_W = 3;
   localparam logic [SPD_DIV_W-1:0] SPD_DIV2 = 3'h0;
   localparam logic [SPD_DIV_W-1:0] SPD_DIV4 = 3'h1;
   localparam logic [SPD_DIV_W-1:0] SPD_DIV8 = 3'h3;
   localparam logic [SPD_DIV_W-1:0] SPD_DIV_LAST = 3'h7;
   localparam logic [11:0] SPD_A_CTRL = 12'h000;
   localparam logic [11:0] SPD_A_STAT = 12'h004;
   localparam logic [11:0] SPD_A_IRQ = 12'h008;
   localparam logic [11:0] SPD_A_MASK = 12'h00c;
   // Control fields: div, inv, still per channel c at bit c*SPD_CTRL_STRIDE; cascade and direction mode are global bits
   localparam int unsigned SPD_CTRL_STRIDE = 4;
   localparam int unsigned SPD_F_DIV = 0;
   localparam int unsigned SPD_F_INV = 1;
   localparam int unsigned SPD_F_STILL = 2;
   localparam int unsigned SPD_F_CASC = 8;
   localparam int unsigned SPD_F_DIRMODE = 9;
   localparam logic [31:0] SPD_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] SPD_CTRL_MASK = 32'h0000_0377;
   // Event bits: still0, still1, direction change
   localparam int unsigned SPD_EV_W = 3;
   localparam int unsigned SPD_EV_DIR = 2;
   localparam logic [SPD_EV_W-1:0] SPD_EV_RST = 3'h0;
   typedef struct packed {
      logic [1:0] meta;
      logic sync;
      logic prev;
   } spd_sync_t;
endpackage : spd_pkg

/* File: spd_chan_if.sv */
// Purpose: Bundle between top and one pulse channel
// Assumes: Single clock domain
// Notes: Config and result signals of a channel
`timescale 1ns/1ps
interface spd_chan_if;
   import spd_pkg::*;
   logic pulseIn;
   logic divEn;
   logic invEn;
   logic stillEn;
   logic [SPD_DIV_W-1:0] divLast;
   logic pulseOut;
   logic still;
   modport top (output pulseIn, divEn, invEn, stillEn, divLast, input pulseOut, still);
   modport chan (input pulseIn, divEn, invEn, stillEn, divLast, output pulseOut, still);
endinterface : spd_chan_if

/* File: spd_channel.sv */
// Purpose: One pulse channel: divider, inversion, standstill timer
// Assumes: pulseIn already synchronised
// Notes: Toggle divider gives 50 % duty for any input duty
`timescale 1ns/1ps
module spd_channel
   import spd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   spd_chan_if.chan ch
);
   typedef struct packed {
      logic prev;
      logic [SPD_DIV_W-1:0] cnt;
      logic half;
      logic [SPD_STILL_W-1:0] idle;
      logic still;
      logic out;
   } spd_ch_st_t;
   spd_ch_st_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.prev = ch.pulseIn;
      if (ch.pulseIn && !s_q.prev) begin
         // Toggle once per half output period of rising edges
         if (s_q.cnt == ch.divLast) begin
            s_d.cnt = '0;
            s_d.half = !s_q.half;
         end else begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
         s_d.idle = '0;
         s_d.still = 1'b0;
      end else if (s_q.idle >= SPD_STILL_W'(SPD_STILL_CYC - 1)) begin
         s_d.still = ch.stillEn;
      end else begin
         s_d.idle = s_q.idle + 1'b1;
      end
      if (!ch.stillEn) begin
         s_d.still = 1'b0;
      end
      // Undivided path copies the level, so zero speed holds steady
      // Next half value keeps divided and undivided paths at equal latency
      s_d.out = (ch.divEn ? s_d.half : ch.pulseIn) ^ ch.invEn;
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign ch.pulseOut = s_q.out;
   assign ch.still = s_q.still;
endmodule : spd_channel

/* File: spd_top.sv */
// Purpose: Speed pulse repeater core with divider, standstill and direction
// Assumes: Sensor inputs asynchronous; APB slave registers
// Notes: Direction variant selected by control bit
// Function
// - Each channel passes pulses undivided or divided by two per its own setting.
// - A build option makes the divided ratio any even value from four to sixteen instead of two.
// - Divided output has equal high and low times whatever the input duty.
// - Cascading the first output into the second input reaches at most two hundred fifty-six.
// - Each channel can invert its output.
// - Undivided output is a steady level copy of the input, even at zero speed.
// - Standstill is flagged when the pulse rate falls below a minimum.
// - The standstill flag asserts below one hertz when detection is enabled.
// - In direction mode the first output carries the travel direction level.
// - Travel direction only updates on a rising edge of the second input.
// - In direction mode the second output repeats the second input pulses.
// - First channel inversion flips the travel direction polarity.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module spd_top
   import spd_pkg::*;
#(
   parameter logic [SPD_DIV_W-1:0] DIV_RATIO_LAST = SPD_DIV2
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic firstInputPulse,
   input wire logic secondInputPulse,
   output logic firstOutputDirectionLevel,
   output logic secondOutputPulse,
   output logic [1:0] standstill,
   output logic irq
);
   typedef struct packed {
      spd_sync_t s0;
      spd_sync_t s1;
      logic [31:0] ctrl;
      logic [SPD_EV_W-1:0] stat;
      logic [SPD_EV_W-1:0] mask;
      logic [1:0] stillPrev;
      logic travelDirection;
      logic out0;
      logic out1;
      logic [31:0] rdata;
   } spd_st_t;
   spd_st_t s_q, s_d;
   spd_chan_if ch0 ();
   spd_chan_if ch1 ();
   logic wrEn;
   logic rdEn;
   logic hit;
   logic dirMode;

   function automatic logic addrHit(input logic [11:0] a);
      addrHit = (a == SPD_A_CTRL) || (a == SPD_A_STAT) || (a == SPD_A_IRQ) || (a == SPD_A_MASK);
   endfunction : addrHit

   function automatic logic ctrlBit(input logic [31:0] c, input int unsigned ch,
                                    input int unsigned f);
      ctrlBit = c[ch * SPD_CTRL_STRIDE + f];
   endfunction : ctrlBit

   assign hit = addrHit(paddr);
   assign wrEn = psel && penable && pwrite && hit;
   assign rdEn = psel && !penable && !pwrite;
   assign dirMode = s_q.ctrl[SPD_F_DIRMODE];

   // Cascade feeds divided first output into second divider: 16 x 16 = 256 max
   assign ch0.pulseIn = s_q.s0.sync;
   // Direction mode ignores cascade so the second output stays a copy of its input
   assign ch1.pulseIn = (s_q.ctrl[SPD_F_CASC] && !dirMode) ? ch0.pulseOut : s_q.s1.sync;
   assign ch0.divEn = ctrlBit(s_q.ctrl, 0, SPD_F_DIV);
   assign ch1.divEn = ctrlBit(s_q.ctrl, 1, SPD_F_DIV) && !dirMode;
   assign ch0.invEn = ctrlBit(s_q.ctrl, 0, SPD_F_INV);
   assign ch1.invEn = ctrlBit(s_q.ctrl, 1, SPD_F_INV);
   assign ch0.stillEn = ctrlBit(s_q.ctrl, 0, SPD_F_STILL);
   assign ch1.stillEn = ctrlBit(s_q.ctrl, 1, SPD_F_STILL);
   assign ch0.divLast = DIV_RATIO_LAST;
   assign ch1.divLast = DIV_RATIO_LAST;

   spd_channel uCh0 (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ch(ch0.chan)
   );
   spd_channel uCh1 (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ch(ch1.chan)
   );

   always_comb begin
      logic [SPD_EV_W-1:0] ev;
      logic [1:0] stillNow;
      ev = '0;
      stillNow = {ch1.still, ch0.still};
      s_d = s_q;
      // First stage feeds only the second stage
      s_d.s0.meta = {s_q.s0.meta[0], firstInputPulse};
      s_d.s0.sync = s_q.s0.meta[1];
      s_d.s0.prev = s_q.s0.sync;
      s_d.s1.meta = {s_q.s1.meta[0], secondInputPulse};
      s_d.s1.sync = s_q.s1.meta[1];
      s_d.s1.prev = s_q.s1.sync;
      if (s_q.s1.sync && !s_q.s1.prev) begin
         s_d.travelDirection = s_q.s0.sync;
         ev[SPD_EV_DIR] = dirMode && (s_q.s0.sync != s_q.travelDirection);
      end
      ev[1:0] = stillNow & ~s_q.stillPrev;
      s_d.stillPrev = stillNow;
      if (dirMode) begin
         s_d.out0 = s_q.travelDirection ^ ch0.invEn;
      end else begin
         s_d.out0 = ch0.pulseOut;
      end
      s_d.out1 = ch1.pulseOut;
      if (wrEn && paddr == SPD_A_CTRL) begin
         s_d.ctrl = pwdata & SPD_CTRL_MASK;
      end
      if (wrEn && paddr == SPD_A_MASK) begin
         s_d.mask = pwdata[SPD_EV_W-1:0];
      end
      // Set wins over a same-cycle write-one clear
      if (wrEn && paddr == SPD_A_IRQ) begin
         s_d.stat = s_q.stat & ~pwdata[SPD_EV_W-1:0];
      end
      s_d.stat = s_d.stat | ev;
      if (rdEn) begin
         unique case (paddr)
            SPD_A_CTRL: s_d.rdata = s_q.ctrl;
            SPD_A_STAT: s_d.rdata = {28'h0000000, dirMode, s_q.travelDirection, stillNow};
            SPD_A_IRQ: s_d.rdata = {29'h00000000, s_q.stat};
            SPD_A_MASK: s_d.rdata = {29'h00000000, s_q.mask};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.ctrl <= SPD_CTRL_RST;
         s_q.stat <= SPD_EV_RST;
         s_q.mask <= SPD_EV_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign firstOutputDirectionLevel = s_q.out0;
   assign secondOutputPulse = s_q.out1;
   assign standstill = {ch1.still, ch0.still};
   assign irq = |(s_q.stat & s_q.mask);
endmodule : spd_top

/* File: spd_sva.sv */
// Purpose: Port checks for spd_top
// Assumes: Outputs lag the input pins by 5 clocks
// Notes: Output checks wait 7 quiet cycles after a control write; the pslverr check does not
`timescale 1ns/1ps
module spd_sva (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic firstInputPulse,
   input wire logic firstOutputDirectionLevel,
   input wire logic secondInputPulse,
   input wire logic secondOutputPulse,
   input wire logic [1:0] standstill
);
   logic [9:0] ctrl_q;
   logic [2:0] calm_q;
   logic [4:0] in1_q;
   logic [5:0] in2_q;
   logic wrCtrl;
   logic ok;
   logic rise2;
   assign wrCtrl = psel && penable && pwrite && paddr == 12'h000;
   // A fresh control write may legally move outputs without an input edge
   assign ok = calm_q == 3'h7;
   assign rise2 = in2_q[4] && !in2_q[5];
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= 10'h000;
         calm_q <= 3'h0;
         in1_q <= 5'h00;
         in2_q <= 6'h00;
      end else begin
         ctrl_q <= wrCtrl ? pwdata[9:0] : ctrl_q;
         calm_q <= wrCtrl ? 3'h0 : calm_q + {2'h0, !ok};
         in1_q <= {in1_q[3:0], firstInputPulse};
         in2_q <= {in2_q[4:0], secondInputPulse};
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_ch1_copy: assert property (ok && !ctrl_q[0] && !ctrl_q[9]
      |-> firstOutputDirectionLevel == (in1_q[4] ^ ctrl_q[1])) else $error("ch1 copy");
   a_ch2_copy: assert property (ok && !ctrl_q[4] && !ctrl_q[8] && !ctrl_q[9]
      |-> secondOutputPulse == (in2_q[4] ^ ctrl_q[5])) else $error("ch2 copy");
   a_ch2_dir: assert property (ok && ctrl_q[9]
      |-> secondOutputPulse == (in2_q[4] ^ ctrl_q[5])) else $error("ch2 in dir mode");
   a_div_edge: assert property (ok && ctrl_q[4] && !ctrl_q[8] && !ctrl_q[9]
      && $changed(secondOutputPulse) |-> rise2) else $error("div toggle");
   a_dir_hold: assert property (ok && ctrl_q[9] && $changed(firstOutputDirectionLevel)
      |-> rise2) else $error("dir moved");
   a_dir_value: assert property (ok && ctrl_q[9] && rise2
      |-> firstOutputDirectionLevel == (in1_q[4] ^ ctrl_q[1])) else $error("dir value");
   a_still_off: assert property (ok
      |-> (standstill & ~{ctrl_q[6], ctrl_q[2]}) == 2'h0) else $error("standstill");
   a_err_map: assert property (psel && penable
      |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c})) else $error("pslverr");
endmodule : spd_sva

bind spd_top spd_sva i_sva (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pslverr, .firstInputPulse, .firstOutputDirectionLevel, .secondInputPulse,
   .secondOutputPulse, .standstill);

/* File: spd_sensor_model.sv */
// Purpose: Two-track speed sensor
// Assumes: Track B lags track A by a quarter period
// Notes: Levels freeze while run is low, as at zero speed
`timescale 1ns/1ps
module spd_sensor_model #(parameter int P = 40, parameter int HB = 10) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic run,
   input wire logic rev,
   output logic pulseA,
   output logic pulseB
);
   int ph;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ph <= 0;
      end else if (run) begin
         ph <= (ph + 1) % P;
      end
   end
   // Reverse shifts A by half a period, so A is low at each B rise
   assign pulseA = (ph < P / 2) ^ rev;
   assign pulseB = ph >= P / 4 && ph < P / 4 + HB;
endmodule : spd_sensor_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for spd_top
// Assumes: 4:1 build, sensor period P clocks, B duty 25 %
// Notes: Standstill needs 2e8 clocks, so only its idle side is seen
`timescale 1ns/1ps
module tb_top;
   import spd_pkg::*;
   localparam int P = 40;
   localparam logic [SPD_DIV_W-1:0] DIVR = SPD_DIV4;
   logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic run = 1'b0, rev = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, fIn, sIn, fOut, sOut, irq, e;
   logic [1:0] standstill;
   int num_errors = 0, num_checks = 0, cyc = 0;
   spd_top #(.DIV_RATIO_LAST(DIVR)) i_dut (.clk_sys, .nrst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .firstInputPulse(fIn),
      .secondInputPulse(sIn), .firstOutputDirectionLevel(fOut), .secondOutputPulse(sOut),
      .standstill, .irq);
   spd_sensor_model #(.P(P), .HB(P / 4)) i_sensor (.clk_sys, .nrst, .run, .rev,
      .pulseA(fIn), .pulseB(sIn));
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Idle edge first, so a release and the next setup never share a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic s_regs();
      apb(1'b0, SPD_A_CTRL, 32'h0);
      chk(r, SPD_CTRL_RST);
      apb(1'b1, SPD_A_CTRL, 32'hffff_ffff);
      apb(1'b0, SPD_A_CTRL, 32'h0);
      chk(r, SPD_CTRL_MASK);
      apb(1'b0, 12'h010, 32'h0);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask : s_regs
   task automatic s_div();
      int hi;
      int lo;
      hi = 0;
      lo = 0;
      apb(1'b1, SPD_A_CTRL, 32'h10);
      run <= 1'b1;
      repeat (8 * P) @(posedge clk_sys);
      wait (sOut === 1'b0);
      wait (sOut === 1'b1);
      @(negedge clk_sys);
      while (sOut === 1'b1) begin
         @(negedge clk_sys);
         hi++;
      end
      while (sOut === 1'b0) begin
         @(negedge clk_sys);
         lo++;
      end
      chk(32'(hi), (DIVR + 1) * P);
      chk(32'(lo), 32'(hi));
   endtask : s_div
   // Both channels divide in series, standstill detection on while pulses run
   task automatic s_casc();
      int hi;
      int lo;
      hi = 0;
      lo = 0;
      apb(1'b1, SPD_A_CTRL, 32'h155);
      repeat (16 * P) @(posedge clk_sys);
      wait (sOut === 1'b0);
      wait (sOut === 1'b1);
      @(negedge clk_sys);
      while (sOut === 1'b1) begin
         @(negedge clk_sys);
         hi++;
      end
      while (sOut === 1'b0) begin
         @(negedge clk_sys);
         lo++;
      end
      chk(32'(hi), 2 * (DIVR + 1) * (DIVR + 1) * P);
      chk(32'(lo), 32'(hi));
      chk({30'h0, standstill}, 32'h0);
      apb(1'b0, SPD_A_STAT, 32'h0);
      chk(r, 32'h4);
   endtask : s_casc
   task automatic s_dir(input logic inv, input logic back);
      apb(1'b1, SPD_A_CTRL, {22'h0, 1'b1, 7'h0, inv, 1'b0});
      rev <= back;
      repeat (3 * P) @(posedge clk_sys);
      chk({31'h0, fOut}, {31'h0, !back ^ inv});
   endtask : s_dir
   task automatic s_irq();
      apb(1'b1, SPD_A_MASK, 32'h0);
      apb(1'b1, SPD_A_IRQ, 32'h7);
      rev <= 1'b0;
      repeat (3 * P) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, SPD_A_IRQ, 32'h0);
      chk(r, 32'h4);
      apb(1'b1, SPD_A_MASK, 32'h4);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, SPD_A_IRQ, 32'h4);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
   endtask : s_irq
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      s_regs();
      s_div();
      for (int i = 0; i < 4; i++) begin
         s_dir(i[0], i[1]);
      end
      s_irq();
      s_casc();
      report_and_stop();
   end
endmodule : tb_top
